//--- core/tff_pkg.sv
// tff_pkg: constants, field layouts, modes and rates of the telemetry frame formatter.
// assumes a single 250 MHz clock; all slower rates come from enable pulses.
`default_nettype none
package tff_pkg;
    // clock and derived counts
    localparam int CLK_HZ = 250_000_000;
    localparam int RATE_MAX_BPS = 40960;
    // coded bits run at twice the information rate; shortest bit time rounds down
    localparam int BASE_DIV = CLK_HZ / (2 * RATE_MAX_BPS);
    localparam int SEC_CYCLES = CLK_HZ;
    // frame layout in information bits and coded bit times
    localparam int FRAME_INFO_BITS = 2048;
    localparam int CODED_BITS = 2 * FRAME_INFO_BITS;
    localparam int SYNC_INFO_BITS = 24;
    localparam int SYNC_CODED_BITS = 2 * SYNC_INFO_BITS;
    localparam int HDR_INFO_BITS = 48;
    localparam int ID_BITS = 8;
    localparam int SUBCOM_BITS = 16;
    localparam int ENG_CHANNELS = 250;
    localparam int PIXEL_BITS = 8;
    localparam int FRAMES_PER_BLOCK = 10;
    localparam int EXP_FRAMES = 9;
    localparam int PIC_BLOCKS = 225;
    // command storage
    localparam int CMD_ENTRIES = 100;
    localparam int CMD_BITS = 60;
    localparam int DUMP_COPIES = 3;
    localparam int F_CODE_HI = 59;
    localparam int F_CODE_LO = 44;
    localparam int F_TIME_HI = 43;
    localparam int F_TIME_LO = 20;
    localparam int F_ADDR_HI = 19;
    localparam int F_ADDR_LO = 1;
    localparam int F_PARITY = 0;
    // rate 1/2, constraint length 7 generators
    localparam logic [6:0] CONV_G1 = 7'h79;
    localparam logic [6:0] CONV_G2 = 7'h5b;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    // ground command opcodes handled inside the block
    localparam logic [15:0] OP_SET_MODE = 16'hf001;
    localparam logic [15:0] OP_SET_RATE = 16'hf002;
    localparam logic [15:0] OP_STORE_ON = 16'hf003;
    localparam logic [15:0] OP_STORE_OFF = 16'hf004;
    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CMD_LO = 8'h04;
    localparam logic [7:0] REG_CMD_HI = 8'h08;
    localparam logic [7:0] REG_CMD_IDX = 8'h0c;
    localparam logic [7:0] REG_TIME = 8'h10;
    localparam int IDX_CLEAR_BIT = 31;
    typedef enum logic [1:0] {
        MODE_SPEC = 2'b00,
        MODE_CAM = 2'b01,
        MODE_ENG = 2'b10,
        MODE_DUMP = 2'b11
    } tff_mode_type;
    typedef enum logic [2:0] {
        RATE_40960 = 3'b000,
        RATE_20480 = 3'b001,
        RATE_10240 = 3'b010,
        RATE_5120 = 3'b011,
        RATE_2048 = 3'b100
    } tff_rate_type;
    localparam tff_mode_type RST_MODE = MODE_ENG;
    localparam tff_rate_type RST_RATE = RATE_20480;
endpackage
`default_nettype wire

//--- core/tff_bit_clock.sv
// tff_bit_clock: coded-bit enable divider for the selected information rate.
// assumes the rate input only changes at frame boundaries.
`timescale 1ns/1ps
`default_nettype none
module tff_bit_clock import tff_pkg::*; #(
    parameter int BASE = BASE_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire tff_rate_type rate,
    output logic bit_en
);
    logic [19:0] cnt;
    logic [19:0] next_cnt;
    logic [19:0] limit;
    logic next_en;

    // divide ratio relative to the fastest rate
    function automatic int mult(input tff_rate_type r);
        case (r)
            RATE_40960: return 1;
            RATE_20480: return 2;
            RATE_10240: return 4;
            RATE_5120: return 8;
            RATE_2048: return 20;
            default: return 2;
        endcase
    endfunction

    // free-running count; one enable pulse per coded bit
    always_comb begin
        limit = 20'(BASE * mult(rate) - 1);
        next_cnt = cnt + 20'h1;
        next_en = 1'b0;
        if (cnt >= limit) begin
            next_cnt = 20'h0;
            next_en = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 20'h0;
            bit_en <= 1'b0;
        end else begin
            cnt <= next_cnt;
            bit_en <= next_en;
        end
    end
endmodule
`default_nettype wire

//--- core/tff_formatter.sv
// tff_formatter: telemetry frame builder, coded serial output and command arbiter.
// assumes sources and command decoder run on CLK; encoder/transmitter takes TX_BIT
// on each TX_STROBE.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tff_formatter import tff_pkg::*; #(
    parameter logic [47:0] SYNC_WORD = 48'h5a3c_96e1_0ff0,
    parameter int BASE_DIV_P = BASE_DIV,
    parameter int SEC_CYCLES_P = SEC_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic RT_VALID,
    input wire logic [15:0] RT_CODE,
    input wire logic [15:0] RT_ARG,
    input wire logic SPEC_VALID,
    input wire logic [7:0] SPEC_DATA,
    output logic SPEC_READY,
    input wire logic CAM_VALID,
    input wire logic [7:0] CAM_DATA,
    output logic CAM_READY,
    output logic [7:0] ENG_CHAN,
    input wire logic [7:0] ENG_DATA,
    input wire logic [7:0] ENG_SUB,
    output logic TX_BIT,
    output logic TX_STROBE,
    output logic TX_SYNC,
    output logic TX_FRAME_START,
    output logic CMD_VALID,
    output logic [15:0] CMD_CODE,
    output logic [18:0] CMD_ADDR,
    output logic CMD_STORED,
    output logic PIC_DONE
);
    localparam logic [3:0] LAST_SLOT = 4'(FRAMES_PER_BLOCK - 1);
    localparam logic [11:0] LAST_CODED = 12'(CODED_BITS - 1);

    // frame engine state
    logic bit_en;
    logic [11:0] cidx, next_cidx;
    logic [3:0] slot, next_slot;
    tff_mode_type mode, next_mode, pend_mode, next_pend_mode;
    tff_rate_type rate, next_rate, pend_rate, next_pend_rate;
    logic [23:0] hdr, next_hdr;
    logic [7:0] byte_sr, next_byte_sr;
    logic [5:0] enc_sr, next_enc_sr;
    logic g2_hold, next_g2_hold;
    logic [7:0] next_eng_chan;
    logic [6:0] d_ent, next_d_ent;
    logic [5:0] d_bit, next_d_bit;
    logic [7:0] pic_blk, next_pic_blk;
    logic next_tx_bit, next_tx_strobe, next_tx_sync, next_frame_start, next_pic_done;
    // frame engine helpers
    logic [10:0] info;
    logic [5:0] sync_idx;
    tff_mode_type kind, nm;
    tff_rate_type nr;
    logic [7:0] src_byte;
    logic cur_bit, g1, g2, rt_mode;
    logic [3:0] ns;
    // command and register state
    logic [CMD_BITS-1:0] cmd_mem [CMD_ENTRIES];
    logic [CMD_ENTRIES-1:0] valid, next_valid;
    logic store_en, next_store_en, missed, next_missed;
    logic [6:0] scan, next_scan;
    logic [23:0] now, next_now;
    logic [27:0] sec_cnt, next_sec;
    logic [31:0] lo, next_lo, next_rdata;
    logic [27:0] hi, next_hi;
    logic next_cmd_valid, next_cmd_stored, mem_we, due;
    logic [15:0] next_cmd_code;
    logic [18:0] next_cmd_addr;
    logic [CMD_BITS-1:0] entry;
    logic [6:0] widx;

    // payload source of a frame: slot 0 of every block is engineering
    function automatic tff_mode_type frame_kind(input tff_mode_type m, input logic [3:0] s);
        return (s == 4'h0) ? MODE_ENG : m;
    endfunction

    tff_bit_clock #(.BASE(BASE_DIV_P)) u_bit_clock (
        .clk(CLK),
        .rst(RST),
        .rate(rate),
        .bit_en(bit_en)
    );

    // frame engine: header, payload selection, encoder and mode/rate switching
    always_comb begin
        next_cidx = cidx;
        next_slot = slot;
        next_mode = mode;
        next_rate = rate;
        next_pend_mode = pend_mode;
        next_pend_rate = pend_rate;
        next_hdr = hdr;
        next_byte_sr = byte_sr;
        next_enc_sr = enc_sr;
        next_g2_hold = g2_hold;
        next_eng_chan = ENG_CHAN;
        next_d_ent = d_ent;
        next_d_bit = d_bit;
        next_pic_blk = pic_blk;
        next_tx_bit = TX_BIT;
        next_tx_sync = TX_SYNC;
        next_tx_strobe = 1'b0;
        next_frame_start = 1'b0;
        next_pic_done = 1'b0;
        SPEC_READY = 1'b0;
        CAM_READY = 1'b0;
        nm = mode;
        nr = rate;
        ns = slot;
        info = cidx[11:1];
        sync_idx = 6'(SYNC_CODED_BITS - 1 - int'(cidx[5:0]));
        kind = frame_kind(mode, slot);
        // ground command picks the next format and rate
        rt_mode = RT_VALID && RT_CODE == OP_SET_MODE;
        if (rt_mode) begin
            next_pend_mode = tff_mode_type'(RT_ARG[1:0]);
        end
        if (RT_VALID && RT_CODE == OP_SET_RATE && RT_ARG[2:0] <= RATE_2048) begin
            next_pend_rate = tff_rate_type'(RT_ARG[2:0]);
        end
        // a missing picture byte becomes fill so the frame never stalls
        case (kind)
            MODE_ENG: src_byte = ENG_DATA;
            MODE_SPEC: src_byte = SPEC_VALID ? SPEC_DATA : FILL_BYTE;
            MODE_CAM: src_byte = CAM_VALID ? CAM_DATA : FILL_BYTE;
            default: src_byte = FILL_BYTE;
        endcase
        if (info < 11'(HDR_INFO_BITS)) begin
            cur_bit = hdr[5'(HDR_INFO_BITS - 1 - int'(info))];
        end else if (kind == MODE_DUMP) begin
            cur_bit = cmd_mem[d_ent][6'(CMD_BITS - 1 - int'(d_bit))];
        end else if (info[2:0] == 3'h0) begin
            cur_bit = src_byte[PIXEL_BITS-1];
        end else begin
            cur_bit = byte_sr[~info[2:0]];
        end
        g1 = ^({cur_bit, enc_sr} & CONV_G1);
        g2 = ^({cur_bit, enc_sr} & CONV_G2);
        if (bit_en) begin
            next_tx_strobe = 1'b1;
            next_frame_start = (cidx == 12'h0);
            next_cidx = cidx + 12'h1;
            if (cidx < 12'(SYNC_CODED_BITS)) begin
                // sync goes out raw, two bit times per information position
                next_tx_bit = SYNC_WORD[sync_idx];
                next_tx_sync = 1'b1;
            end else if (!cidx[0]) begin
                next_tx_bit = g1;
                next_tx_sync = 1'b0;
                next_g2_hold = g2;
                next_enc_sr = {cur_bit, enc_sr[5:1]};
                if (info >= 11'(HDR_INFO_BITS)) begin
                    if (kind == MODE_DUMP) begin
                        // 100 x 60 bits walked three times over nine frames
                        if (d_bit == 6'(CMD_BITS - 1)) begin
                            next_d_bit = 6'h0;
                            next_d_ent = (d_ent == 7'(CMD_ENTRIES - 1)) ? 7'h0 : d_ent + 7'h1;
                        end else begin
                            next_d_bit = d_bit + 6'h1;
                        end
                    end else if (info[2:0] == 3'h0) begin
                        next_byte_sr = src_byte;
                        SPEC_READY = (kind == MODE_SPEC) && SPEC_VALID;
                        CAM_READY = (kind == MODE_CAM) && CAM_VALID;
                        if (kind == MODE_ENG) begin
                            next_eng_chan = ENG_CHAN + 8'h1;
                        end
                    end
                end
            end else begin
                next_tx_bit = g2_hold;
            end
            if (cidx == LAST_CODED) begin
                // changes land only here, so no partial frame is sent
                nm = pend_mode;
                nr = pend_rate;
                if (mode == MODE_DUMP && slot == LAST_SLOT && pend_mode == MODE_DUMP) begin
                    nm = MODE_ENG;
                    if (!rt_mode) begin
                        next_pend_mode = MODE_ENG;
                    end
                end
                if (nr == RATE_2048 && nm != MODE_ENG) begin
                    nr = RATE_20480;
                end
                if (nm != mode) begin
                    ns = 4'h0;
                end else begin
                    ns = (slot == LAST_SLOT) ? 4'h0 : slot + 4'h1;
                end
                if (nm != mode || nm != MODE_SPEC) begin
                    next_pic_blk = 8'h0;
                end else if (slot == LAST_SLOT) begin
                    if (pic_blk == 8'(PIC_BLOCKS - 1)) begin
                        next_pic_blk = 8'h0;
                        next_pic_done = 1'b1;
                    end else begin
                        next_pic_blk = pic_blk + 8'h1;
                    end
                end
                next_mode = nm;
                next_rate = nr;
                next_slot = ns;
                next_eng_chan = 8'h0;
                if (ns == 4'h0) begin
                    next_d_ent = 7'h0;
                    next_d_bit = 6'h0;
                end
                // id byte: mode and slot; subcom: sensor byte then status
                next_hdr = {nm, 2'b00, ns, ENG_SUB, missed, store_en, nr, 3'b000};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cidx <= 12'h0;
            slot <= 4'h0;
            mode <= RST_MODE;
            rate <= RST_RATE;
            pend_mode <= RST_MODE;
            pend_rate <= RST_RATE;
            hdr <= {RST_MODE, 22'h0};
            byte_sr <= 8'h0;
            enc_sr <= 6'h0;
            g2_hold <= 1'b0;
            ENG_CHAN <= 8'h0;
            d_ent <= 7'h0;
            d_bit <= 6'h0;
            pic_blk <= 8'h0;
            TX_BIT <= 1'b0;
            TX_STROBE <= 1'b0;
            TX_SYNC <= 1'b0;
            TX_FRAME_START <= 1'b0;
            PIC_DONE <= 1'b0;
        end else begin
            cidx <= next_cidx;
            slot <= next_slot;
            mode <= next_mode;
            rate <= next_rate;
            pend_mode <= next_pend_mode;
            pend_rate <= next_pend_rate;
            hdr <= next_hdr;
            byte_sr <= next_byte_sr;
            enc_sr <= next_enc_sr;
            g2_hold <= next_g2_hold;
            ENG_CHAN <= next_eng_chan;
            d_ent <= next_d_ent;
            d_bit <= next_d_bit;
            pic_blk <= next_pic_blk;
            TX_BIT <= next_tx_bit;
            TX_STROBE <= next_tx_strobe;
            TX_SYNC <= next_tx_sync;
            TX_FRAME_START <= next_frame_start;
            PIC_DONE <= next_pic_done;
        end
    end

    // command arbiter, mission clock and register port
    always_comb begin
        next_valid = valid;
        next_store_en = store_en;
        next_missed = missed;
        next_scan = scan;
        next_now = now;
        next_sec = sec_cnt + 28'h1;
        next_lo = lo;
        next_hi = hi;
        next_cmd_valid = 1'b0;
        next_cmd_stored = 1'b0;
        next_cmd_code = CMD_CODE;
        next_cmd_addr = CMD_ADDR;
        next_rdata = 32'h0;
        mem_we = 1'b0;
        widx = WDATA[6:0];
        entry = cmd_mem[scan];
        if (sec_cnt == 28'(SEC_CYCLES_P - 1)) begin
            next_sec = 28'h0;
            next_now = now + 24'h1;
        end
        // status clear first so a same-cycle miss still sets the flag
        if (WR && ADDR == REG_STATUS && WDATA[0]) begin
            next_missed = 1'b0;
        end
        due = store_en && valid[scan] && entry[F_TIME_HI:F_TIME_LO] == now;
        if (RT_VALID) begin
            next_cmd_valid = 1'b1;
            next_cmd_code = RT_CODE;
            next_cmd_addr = {3'b000, RT_ARG};
            if (RT_CODE == OP_STORE_ON) begin
                next_store_en = 1'b1;
            end else if (RT_CODE == OP_STORE_OFF) begin
                next_store_en = 1'b0;
            end
            if (due) begin
                next_missed = 1'b1;
            end
        end else if (due) begin
            next_cmd_valid = 1'b1;
            next_cmd_stored = 1'b1;
            next_cmd_code = entry[F_CODE_HI:F_CODE_LO];
            next_cmd_addr = entry[F_ADDR_HI:F_ADDR_LO];
            next_valid[scan] = 1'b0;
        end
        // a blocked entry is retried on the next cycle
        if (!(RT_VALID && due)) begin
            next_scan = (scan == 7'(CMD_ENTRIES - 1)) ? 7'h0 : scan + 7'h1;
        end
        if (WR) begin
            case (ADDR)
                REG_CMD_LO: next_lo = WDATA;
                REG_CMD_HI: next_hi = WDATA[27:0];
                REG_CMD_IDX: begin
                    if (widx < 7'(CMD_ENTRIES)) begin
                        next_valid[widx] = !WDATA[IDX_CLEAR_BIT];
                        mem_we = !WDATA[IDX_CLEAR_BIT];
                    end
                end
                default: next_lo = lo;
            endcase
        end
        if (RD) begin
            case (ADDR)
                REG_STATUS: next_rdata = {12'h0, slot, pic_blk, 1'b0, mode, rate, store_en, missed};
                REG_CMD_LO: next_rdata = lo;
                REG_CMD_HI: next_rdata = {4'h0, hi};
                REG_TIME: next_rdata = {8'h0, now};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // storage array carries no reset; the valid bits guard stored execution, but the dump reads every entry
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            cmd_mem[widx] <= {hi, lo};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            valid <= '0;
            store_en <= 1'b0;
            missed <= 1'b0;
            scan <= 7'h0;
            now <= 24'h0;
            sec_cnt <= 28'h0;
            lo <= 32'h0;
            hi <= 28'h0;
            RDATA <= 32'h0;
            CMD_VALID <= 1'b0;
            CMD_STORED <= 1'b0;
            CMD_CODE <= 16'h0;
            CMD_ADDR <= 19'h0;
        end else begin
            valid <= next_valid;
            store_en <= next_store_en;
            missed <= next_missed;
            scan <= next_scan;
            now <= next_now;
            sec_cnt <= next_sec;
            lo <= next_lo;
            hi <= next_hi;
            RDATA <= next_rdata;
            CMD_VALID <= next_cmd_valid;
            CMD_STORED <= next_cmd_stored;
            CMD_CODE <= next_cmd_code;
            CMD_ADDR <= next_cmd_addr;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence rt_meets_due;
        RT_VALID && due;
    endsequence

    sync_uncoded_a: assert property (
        bit_en && cidx < 12'(SYNC_CODED_BITS) |=> TX_SYNC && TX_BIT == SYNC_WORD[$past(sync_idx)])
        else $error("sync bit wrong or coded");
    mode_boundary_a: assert property (
        $changed(mode) || $changed(rate) |-> $past(bit_en) && $past(cidx) == LAST_CODED)
        else $error("mode or rate changed inside a frame");
    slow_rate_a: assert property (
        rate == RATE_2048 |-> mode == MODE_ENG)
        else $error("2048 rate outside engineering mode");
    rt_first_a: assert property (
        rt_meets_due |=> CMD_VALID && !CMD_STORED && missed && CMD_CODE == $past(RT_CODE))
        else $error("real-time command lost priority");
    store_gate_a: assert property (
        $changed(store_en) |-> $past(RT_VALID) && ($past(RT_CODE) == OP_STORE_ON ||
        $past(RT_CODE) == OP_STORE_OFF))
        else $error("stored enable changed without ground command");
    eng_only_a: assert property (
        $changed(ENG_CHAN) && ENG_CHAN != 8'h0 |-> $past(frame_kind(mode, slot)) == MODE_ENG)
        else $error("engineering channel advanced outside engineering frame");
    eng_span_a: assert property (
        ENG_CHAN <= 8'(ENG_CHANNELS))
        else $error("engineering channel past last");
    dump_end_a: assert property (
        mode == MODE_DUMP && slot == LAST_SLOT && pend_mode == MODE_DUMP && bit_en &&
        cidx == LAST_CODED |=> mode == MODE_ENG && slot == 4'h0)
        else $error("dump did not end after one block");
    pic_end_a: assert property (
        PIC_DONE |-> pic_blk == 8'h0 && $past(pic_blk) == 8'(PIC_BLOCKS - 1))
        else $error("picture end not after 225 blocks");
    read_slot_a: assert property (
        !$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

//--- testbench/tff_link_sink.sv
// tff_link_sink: stand-in for the encoder and transmitter.
// assumes it takes TX_BIT on each strobe, on the formatter's clock.
`timescale 1ns/1ps
`default_nettype none
module tff_link_sink (
    input wire logic clk,
    input wire logic strobe,
    input wire logic bit_in,
    input wire logic frame_start,
    output logic [47:0] sync_seen,
    output int n,
    output int gap
);
    int cnt = 0;
    // keep the raw leading bits of a frame and time the strobe spacing
    always @(posedge clk) begin
        cnt <= cnt + 1;
        if (strobe) begin
            gap <= cnt + 1;
            cnt <= 0;
            n <= frame_start ? 1 : n + 1;
            if (frame_start || n < 48) sync_seen <= {sync_seen[46:0], bit_in};
        end
    end
endmodule
`default_nettype wire

//--- testbench/tff_formatter_test.sv
// tff_formatter_test: self-checking bench for the frame formatter.
// assumes the link sink model on the serial side; picture inputs idle.
`timescale 1ns/1ps
`default_nettype none
module tff_formatter_test import tff_pkg::*;;
    localparam logic [47:0] SW = 48'h1234_5678_9abc; // arbitrary pattern
    localparam int BD = 4;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, RT_VALID = 0, rd_d = 0;
    logic [7:0] ADDR = 0, ENG_DATA = 0, ENG_SUB = 0;
    logic [31:0] WDATA = 0, RDATA, r, seed = 32'ha9d0748b;
    logic [15:0] RT_CODE = 0, RT_ARG = 0, CMD_CODE;
    logic [18:0] CMD_ADDR;
    logic CMD_VALID, CMD_STORED, TX_BIT, TX_STROBE, TX_FRAME_START, TX_SYNC;
    logic [7:0] ENG_CHAN;
    logic [47:0] sync_seen;
    logic [35:0] cq[$];
    logic [31:0] rq[$];
    int n_mismatch = 0, total_checks = 0, cyc = 0, n, gap;
    tff_formatter #(.SYNC_WORD(SW), .BASE_DIV_P(BD), .SEC_CYCLES_P(1000)) DUT (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RT_VALID(RT_VALID), .RT_CODE(RT_CODE), .RT_ARG(RT_ARG),
        .SPEC_VALID(1'b0), .SPEC_DATA(8'h00), .SPEC_READY(), .CAM_VALID(1'b0),
        .CAM_DATA(8'h00), .CAM_READY(), .ENG_CHAN(ENG_CHAN), .ENG_DATA(ENG_DATA),
        .ENG_SUB(ENG_SUB), .TX_BIT(TX_BIT), .TX_STROBE(TX_STROBE), .TX_SYNC(TX_SYNC),
        .TX_FRAME_START(TX_FRAME_START), .CMD_VALID(CMD_VALID),
        .CMD_CODE(CMD_CODE), .CMD_ADDR(CMD_ADDR), .CMD_STORED(CMD_STORED),
        .PIC_DONE());
    tff_link_sink LINK (.clk(CLK), .strobe(TX_STROBE), .bit_in(TX_BIT),
        .frame_start(TX_FRAME_START), .sync_seen(sync_seen), .n(n), .gap(gap));
    task automatic chk(string nm, logic [47:0] s, logic [47:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // channel index shown after coded bit k of an engineering frame; cleared on the last bit
    function automatic logic [7:0] eng_exp(int k);
        if (k < 2 * HDR_INFO_BITS || k >= CODED_BITS - 1) return 8'h00;
        return 8'((k - 2 * HDR_INFO_BITS) / (2 * PIXEL_BITS) + 1);
    endfunction
    // one bus cycle; on a read the data word is the expected answer
    task automatic bus(logic w, logic rd, logic [7:0] a, logic [31:0] d);
        WR <= w;
        RD <= rd;
        ADDR <= a;
        WDATA <= d;
        if (rd) rq.push_back(d);
        @(posedge CLK);
    endtask
    task automatic rt(logic [15:0] c, logic [15:0] a);
        RT_VALID <= 1;
        RT_CODE <= c;
        RT_ARG <= a;
        cq.push_back({1'b0, c, 3'b000, a});
        @(posedge CLK);
    endtask
    // free-running 4 ns clock
    initial begin
        forever #2 CLK = ~CLK;
    end
    // watcher: pairs each answer with the oldest note, feeds sensors, timeout
    always @(posedge CLK) begin
        rd_d <= RD;
        if (rd_d) chk("rdata", RDATA, rq.pop_front());
        // an unknown valid still consumes a note, so it cannot slip past unseen
        if (CMD_VALID !== 1'b0) begin
            chk("cmd", {CMD_STORED, CMD_CODE, CMD_ADDR}, cq.pop_front());
        end
        // per coded bit: position taken from the sink's own count, not from the design
        if (TX_STROBE) begin
            chk("fstart", TX_FRAME_START, n == 0 || n == CODED_BITS);
            chk("txsync", TX_SYNC, n == CODED_BITS || n < SYNC_CODED_BITS);
            chk("engchan", ENG_CHAN, eng_exp(n));
        end
        cyc <= cyc + 1;
        ENG_DATA <= cyc[7:0];
        ENG_SUB <= cyc[15:8];
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end
    // stimulus: registers, ground and stored commands, then a rate switch at a frame end
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        bus(0, 1, REG_STATUS, 32'h44);
        bus(0, 1, 8'h20, 0);
        bus(0, 1, REG_TIME, 0);
        // entry 99: code abcd, due at second 1, address 1234
        bus(1, 0, REG_CMD_LO, 32'h0010_2468);
        bus(1, 0, REG_CMD_HI, 32'h0abc_d000);
        bus(1, 0, REG_CMD_IDX, 32'd99);
        bus(0, 0, 8'h00, 0);
        rt(OP_STORE_ON, 16'h0000);
        RT_VALID <= 0;
        repeat (2) @(posedge CLK);
        bus(0, 1, REG_STATUS, 32'h46);
        bus(0, 0, 8'h00, 0);
        // back-to-back ground traffic hides the due entry until it stops
        for (int i = 0; i < 1100; i++) begin
            r = rnd();
            rt({1'b0, r[30:16]}, r[15:0]);
        end
        RT_VALID <= 0;
        cq.push_back({1'b1, 16'habcd, 19'h01234});
        for (int i = 0; i < 150 && cq.size() > 0; i++) @(posedge CLK);
        bus(0, 1, REG_STATUS, 32'h47);
        bus(1, 0, REG_STATUS, 32'h1);
        bus(0, 1, REG_STATUS, 32'h46);
        bus(0, 0, 8'h00, 0);
        repeat (2) @(posedge CLK);
        chk("sync", sync_seen, SW);
        chk("gap", gap, 2 * BD);
        // the new rate must wait for the frame end; an out-of-range code is refused
        rt(OP_SET_RATE, 16'h0000);
        rt(OP_SET_RATE, 16'h0005);
        rt(OP_STORE_OFF, 16'h0000);
        RT_VALID <= 0;
        repeat (2) @(posedge CLK);
        bus(0, 1, REG_STATUS, 32'h44);
        bus(0, 0, 8'h00, 0);
        for (int i = 0; i < 40000 && !TX_FRAME_START; i++) @(posedge CLK);
        repeat (100 * BD) @(posedge CLK);
        chk("fastgap", gap, BD);
        bus(0, 1, REG_STATUS, 32'h0001_0040);
        bus(0, 0, 8'h00, 0);
        repeat (2) @(posedge CLK);
        chk("left", cq.size() + rq.size(), 0);
        results();
    end
endmodule
`default_nettype wire
